/* File: design/shared_parallel_io_port.sv */
// parallel io ports a to c with axi4-lite registers and shared pad control
// Function
// - active peripheral disables port driver, pin readable
// - enabled idle peripheral leaves pin to port
// - direction one is input, zero drives latch
// - reset sets every implemented direction bit
// - latch register reads latch, writes latch
// - level register reads pins, writes latch
// - unimplemented bits disabled and read zero
// - input-only alternates make a dedicated pin
// - peripheral has priority on data and enable
// - analog-configured pins read zero as level
// - digital inputs never routed to converter
// - three word registers per port from base
// - level and latch reset zero, direction set
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps

module shared_parallel_io_port #(
   parameter int NUM_PORTS = 3,
   parameter int PORT_WIDTH = 16,
   parameter logic [NUM_PORTS*PORT_WIDTH-1:0] IMPL_MASK =
      {gpio_pkg::PORT_C_MASK, gpio_pkg::PORT_B_MASK, gpio_pkg::PORT_A_MASK},
   parameter logic [NUM_PORTS*PORT_WIDTH-1:0] DEDICATED_MASK = '0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [11:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic [NUM_PORTS*PORT_WIDTH-1:0] pin_in,
   output logic [NUM_PORTS*PORT_WIDTH-1:0] pin_out,
   output logic [NUM_PORTS*PORT_WIDTH-1:0] pin_oe,
   input wire logic [NUM_PORTS*PORT_WIDTH-1:0] periph_en,
   input wire logic [NUM_PORTS*PORT_WIDTH-1:0] periph_drive,
   input wire logic [NUM_PORTS*PORT_WIDTH-1:0] periph_out,
   input wire logic [PORT_WIDTH-1:0] analog_pin_config,
   output logic [PORT_WIDTH-1:0] analog_route
);

   // all pins side by side: port a low, then b, then c
   localparam int W = NUM_PORTS * PORT_WIDTH;

   // =====================================================
   // complete state of the block
   // one register holds everything, so reset and update stay in one place
   typedef struct packed {
      logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] dir; // direction, one is input
      logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] lat; // output latches
      logic [W-1:0] sync1; // first synchroniser stage
      logic [W-1:0] sync2; // sampled pin levels
      logic aw_got; // write address held
      logic [9:0] aw_idx; // held write word index
      logic w_got; // write data held
      logic [PORT_WIDTH-1:0] wdata; // held write data
      logic [1:0] wstrb; // held byte enables
      logic bvalid; // write response pending
      logic [1:0] bresp; // write response code
      logic rvalid; // read data pending
      logic [PORT_WIDTH-1:0] rdata; // read data
      logic [1:0] rresp; // read response code
   } state_type;

   state_type s_r; // registered state
   state_type s_nxt; // next state
   gpio_pkg::decode_type wr_dec; // decode of held write address
   gpio_pkg::decode_type rd_dec; // decode of read address
   logic wr_fire; // write committed this cycle
   logic rd_take; // read address taken this cycle
   logic [PORT_WIDTH-1:0] merged; // byte-merged write value
   logic [PORT_WIDTH-1:0] port_mask; // implemented bits of write port
   logic [PORT_WIDTH-1:0] rd_mask; // implemented bits of read port
   logic [PORT_WIDTH-1:0] rd_level; // visible pin levels of read port
   logic [W-1:0] dir_flat; // flattened direction
   logic [W-1:0] lat_flat; // flattened latches
   logic [W-1:0] dir_pad; // direction seen by the pads

   // =====================================================
   // bus handshakes; one write and one read at a time
   // a write commits once both halves are held, a read answers on the next edge
   // readies depend on registers alone, so no valid-to-ready loop exists
   assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
   assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
   assign s_axi_arready = !s_r.rvalid;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = {16'h0000, s_r.rdata};
   assign s_axi_rresp = s_r.rresp;
   assign wr_fire = s_r.aw_got && s_r.w_got;
   assign rd_take = s_axi_arvalid && s_axi_arready;
   assign wr_dec = gpio_pkg::decode_idx(s_r.aw_idx);
   assign rd_dec = gpio_pkg::decode_idx(s_axi_araddr[11:2]);
   assign dir_flat = s_r.dir;
   assign lat_flat = s_r.lat;
   // pins that do not exist stay inputs so the port never drives their pad
   assign dir_pad = dir_flat | ~IMPL_MASK;

   // =====================================================
   // converter sees only pins configured as analog
   // only port b pins double as converter inputs
   assign analog_route = analog_pin_config;

   // =====================================================
   // pad ownership
   // a driving peripheral wins data and enable; dedicated pins follow the port
   pad_output_mux #(
      .WIDTH(W)
   ) u_pad_mux (
      .port_dir(dir_pad),
      .port_lat(lat_flat),
      .periph_en(periph_en),
      .periph_drive(periph_drive),
      .periph_out(periph_out),
      .dedicated(DEDICATED_MASK),
      .pad_out(pin_out),
      .pad_oe(pin_oe)
   );

   // =====================================================
   // next-state logic
   always_comb begin
      s_nxt = s_r;
      port_mask = IMPL_MASK[wr_dec.port*PORT_WIDTH +: PORT_WIDTH];
      rd_mask = IMPL_MASK[rd_dec.port*PORT_WIDTH +: PORT_WIDTH];
      // sampled levels, implemented bits only; analog pins read low
      rd_level = s_r.sync2[rd_dec.port*PORT_WIDTH +: PORT_WIDTH] & rd_mask;
      if (rd_dec.port == gpio_pkg::ANALOG_PORT) begin
         rd_level = rd_level & ~analog_pin_config;
      end
      // byte lane merge of held write data
      merged = s_r.wdata;
      if (wr_dec.hit) begin
         if (!s_r.wstrb[0]) begin
            merged[7:0] = (wr_dec.kind == gpio_pkg::KIND_DIR) ? s_r.dir[wr_dec.port][7:0]
                                                              : s_r.lat[wr_dec.port][7:0];
         end
         if (!s_r.wstrb[1]) begin
            merged[15:8] = (wr_dec.kind == gpio_pkg::KIND_DIR) ? s_r.dir[wr_dec.port][15:8]
                                                               : s_r.lat[wr_dec.port][15:8];
         end
      end
      // two-stage pin synchroniser
      // a level read therefore shows a pad change two edges late
      s_nxt.sync1 = pin_in;
      s_nxt.sync2 = s_r.sync1;
      // capture write address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.aw_idx = s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = s_axi_wdata[15:0];
         s_nxt.wstrb = s_axi_wstrb[1:0];
      end
      // commit the write once both halves are held
      if (wr_fire) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = wr_dec.hit ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
         if (wr_dec.hit) begin
            case (wr_dec.kind)
               gpio_pkg::KIND_DIR: begin
                  s_nxt.dir[wr_dec.port] = merged & port_mask;
               end
               gpio_pkg::KIND_LEVEL: begin
                  s_nxt.lat[wr_dec.port] = merged & port_mask;
               end
               default: begin
                  s_nxt.lat[wr_dec.port] = merged & port_mask;
               end
            endcase
         end
      end else if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      // read data from the registered state
      if (rd_take) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = rd_dec.hit ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
         if (!rd_dec.hit) begin
            s_nxt.rdata = '0;
         end else if (rd_dec.kind == gpio_pkg::KIND_DIR) begin
            s_nxt.rdata = s_r.dir[rd_dec.port];
         end else if (rd_dec.kind == gpio_pkg::KIND_LEVEL) begin
            s_nxt.rdata = rd_level;
         end else begin
            s_nxt.rdata = s_r.lat[rd_dec.port];
         end
      end else if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
   end

   // =====================================================
   // state register with synchronous reset
   // direction is overwritten with the mask so every real pin starts as input
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.dir <= IMPL_MASK;
      end else begin
         s_r <= s_nxt;
      end
   end

   // =====================================================
   // checks
   // all properties run on aclk and stay silent while reset is asserted
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic [W-1:0] own_chk; // pins a peripheral currently owns
   assign own_chk = periph_en & periph_drive & ~DEDICATED_MASK;

   // peripheral data and enable take the pad
   periph_takeover_a: assert property ((pin_oe & own_chk) == own_chk && ((pin_out ^ periph_out) & own_chk) == '0)
      else $error("peripheral does not own its pad");
   // idle peripheral leaves pad to the port direction
   port_drive_a: assert property (((pin_oe ^ ~dir_pad) & ~own_chk) == '0)
      else $error("port enable wrong on a free pin");
   // latch drives data on free output pins
   latch_data_a: assert property ((((pin_out ^ lat_flat) & ~own_chk)) == '0)
      else $error("latch not on free pad");
   // direction comes out of reset set on every implemented bit
   reset_dir_a: assert property ($rose(aresetn) |-> dir_flat == IMPL_MASK && lat_flat == '0)
      else $error("wrong values after reset");
   // latch read returns latch contents
   latch_read_a: assert property (rd_take && rd_dec.hit && rd_dec.kind == gpio_pkg::KIND_LAT
      |=> s_axi_rvalid && s_axi_rdata[15:0] == $past(lat_flat[rd_dec.port*PORT_WIDTH +: PORT_WIDTH]))
      else $error("latch read mismatch");
   // level write lands in the latch
   level_write_a: assert property (wr_fire && wr_dec.hit && wr_dec.kind == gpio_pkg::KIND_LEVEL
      && s_r.wstrb == 2'b11 |=> s_r.lat[$past(wr_dec.port)] == $past(s_r.wdata & port_mask))
      else $error("level write did not reach latch");
   // unimplemented bits stay zero
   unimpl_zero_a: assert property (((dir_flat | lat_flat) & ~IMPL_MASK) == '0)
      else $error("unimplemented bit set");
   // dedicated pins ignore peripherals
   dedicated_pin_a: assert property (((pin_oe ^ ~dir_pad) & DEDICATED_MASK) == '0)
      else $error("dedicated pin taken over");
   // analog pins read low in the level register
   analog_zero_a: assert property (rd_take && rd_dec.hit && rd_dec.kind == gpio_pkg::KIND_LEVEL
      && rd_dec.port == gpio_pkg::ANALOG_PORT |=> (s_axi_rdata[15:0] & $past(analog_pin_config)) == '0)
      else $error("analog pin read nonzero");
   // write answers on the edge after commit, with an error if unmapped
   write_resp_a: assert property (wr_fire |=> s_axi_bvalid && (s_axi_bresp == gpio_pkg::RESP_OKAY) == $past(wr_dec.hit))
      else $error("write response wrong");
   // level sample lags the pins by two clocks
   sync_lag_a: assert property ($past(aresetn, 2) |-> s_r.sync2 == $past(pin_in, 2))
      else $error("synchroniser lag wrong");

   // pins that do not exist drive a pad only when a peripheral owns them
   unimpl_pad_a: assert property ((pin_oe & ~IMPL_MASK & ~own_chk) == '0)
      else $error("missing pin enabled");

   unimpl_data_a: assert property ((pin_out & ~IMPL_MASK & ~own_chk) == '0)
      else $error("missing pin shows data");

   // a dedicated pin always shows its latch
   dedicated_data_a: assert property (((pin_out ^ lat_flat) & DEDICATED_MASK) == '0)
      else $error("dedicated pin data taken over");

   // direction read returns the stored direction
   dir_read_a: assert property (rd_take && rd_dec.hit && rd_dec.kind == gpio_pkg::KIND_DIR
      |=> s_axi_rvalid && s_axi_rdata[15:0] == $past(dir_flat[rd_dec.port*PORT_WIDTH +: PORT_WIDTH]))
      else $error("direction read mismatch");

   // level read shows sampled pins on implemented bits only
   level_read_a: assert property (rd_take && rd_dec.hit && rd_dec.kind == gpio_pkg::KIND_LEVEL
      |=> (s_axi_rdata[15:0] & ~$past(rd_mask)) == '0
      && (s_axi_rdata[15:0] & ~$past(s_r.sync2[rd_dec.port*PORT_WIDTH +: PORT_WIDTH])) == '0)
      else $error("level read mismatch");

   // unmapped read answers with an error and zero data
   unmapped_read_a: assert property (rd_take && !rd_dec.hit
      |=> s_axi_rvalid && s_axi_rresp == gpio_pkg::RESP_SLVERR && s_axi_rdata == '0)
      else $error("unmapped read answered");

   // answers rise only for a request and fall once taken
   rvalid_rose_a: assert property ($rose(s_axi_rvalid) |-> $past(rd_take))
      else $error("read answer without request");

   bvalid_rose_a: assert property ($rose(s_axi_bvalid) |-> $past(wr_fire))
      else $error("write answer without commit");

   read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");

   write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");

   // full-word writes store the implemented bits
   latch_write_a: assert property (wr_fire && wr_dec.hit && wr_dec.kind == gpio_pkg::KIND_LAT
      && s_r.wstrb == 2'b11 |=> s_r.lat[$past(wr_dec.port)] == $past(s_r.wdata & port_mask))
      else $error("latch write lost");

   dir_write_a: assert property (wr_fire && wr_dec.hit && wr_dec.kind == gpio_pkg::KIND_DIR
      && s_r.wstrb == 2'b11 |=> s_r.dir[$past(wr_dec.port)] == $past(s_r.wdata & port_mask))
      else $error("direction write lost");

   // a low-byte-only latch write keeps the high byte
   strobe_keep_a: assert property (wr_fire && wr_dec.hit && wr_dec.kind == gpio_pkg::KIND_LAT
      && s_r.wstrb == 2'b01 |=> s_r.lat[$past(wr_dec.port)][15:8] == $past(s_r.lat[wr_dec.port][15:8]))
      else $error("unstrobed byte changed");

   // an unmapped write changes no register
   unmapped_write_a: assert property (wr_fire && !wr_dec.hit |=> $stable(s_r.dir) && $stable(s_r.lat))
      else $error("unmapped write landed");

   // reset clears samples, read data and pending answers
   reset_sync_a: assert property ($rose(aresetn) |-> s_r.sync2 == '0 && s_r.rdata == '0)
      else $error("level state not cleared by reset");

   reset_ready_a: assert property ($rose(aresetn) |-> s_axi_awready && s_axi_wready && s_axi_arready
      && !s_axi_bvalid && !s_axi_rvalid)
      else $error("bus not idle after reset");

   // main scenarios
   cover_takeover: cover property (|own_chk);
   cover_level_write: cover property (wr_fire && wr_dec.kind == gpio_pkg::KIND_LEVEL);
   cover_unmapped: cover property (s_axi_rvalid && s_axi_rresp == gpio_pkg::RESP_SLVERR);
   cover_analog_read: cover property (rd_take && rd_dec.port == gpio_pkg::ANALOG_PORT && |analog_pin_config);
   cover_byte_write: cover property (wr_fire && s_r.wstrb != 2'b11);

endmodule

/* File: design/gpio_pkg.sv */
// shared constants, register indices and decode helper for the parallel io port
package gpio_pkg;

   // =====================================================
   // register indices (byte address is four times the index)
   localparam logic [9:0] PORT_A_DIR_IDX = 10'h2C0;
   localparam logic [9:0] PORT_A_LEVEL_IDX = 10'h2C2;
   localparam logic [9:0] PORT_A_LAT_IDX = 10'h2C4;
   localparam logic [9:0] PORT_B_DIR_IDX = 10'h2C6;
   localparam logic [9:0] PORT_B_LEVEL_IDX = 10'h2C8;
   localparam logic [9:0] PORT_B_LAT_IDX = 10'h2CB;
   localparam logic [9:0] PORT_C_DIR_IDX = 10'h2CC;
   localparam logic [9:0] PORT_C_LEVEL_IDX = 10'h2CE;
   localparam logic [9:0] PORT_C_LAT_IDX = 10'h2D0;

   // =====================================================
   // implemented bits; direction resets to these, the rest reset to zero
   localparam logic [15:0] PORT_A_MASK = 16'hC600;
   localparam logic [15:0] PORT_B_MASK = 16'hFFFF;
   localparam logic [15:0] PORT_C_MASK = 16'hE00A;
   localparam logic [15:0] LEVEL_RESET = 16'h0000;
   localparam logic [15:0] LAT_RESET = 16'h0000;

   // port whose pins double as analog inputs
   localparam logic [1:0] ANALOG_PORT = 2'h1;

   // =====================================================
   // bus response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // register kind within a port
   typedef enum logic [1:0] {
      KIND_DIR = 2'b00,
      KIND_LEVEL = 2'b01,
      KIND_LAT = 2'b10
   } kind_type;

   // result of an address decode
   typedef struct packed {
      logic hit;
      logic [1:0] port;
      kind_type kind;
   } decode_type;

   // map a word index onto port and register kind
   function automatic decode_type decode_idx(input logic [9:0] idx);
      decode_type d;
      d = '{hit: 1'b1, port: 2'h0, kind: KIND_DIR};
      if (idx == PORT_A_DIR_IDX) begin
         d.port = 2'h0;
      end else if (idx == PORT_A_LEVEL_IDX) begin
         d.port = 2'h0;
         d.kind = KIND_LEVEL;
      end else if (idx == PORT_A_LAT_IDX) begin
         d.port = 2'h0;
         d.kind = KIND_LAT;
      end else if (idx == PORT_B_DIR_IDX) begin
         d.port = 2'h1;
      end else if (idx == PORT_B_LEVEL_IDX) begin
         d.port = 2'h1;
         d.kind = KIND_LEVEL;
      end else if (idx == PORT_B_LAT_IDX) begin
         d.port = 2'h1;
         d.kind = KIND_LAT;
      end else if (idx == PORT_C_DIR_IDX) begin
         d.port = 2'h2;
      end else if (idx == PORT_C_LEVEL_IDX) begin
         d.port = 2'h2;
         d.kind = KIND_LEVEL;
      end else if (idx == PORT_C_LAT_IDX) begin
         d.port = 2'h2;
         d.kind = KIND_LAT;
      end else begin
         d.hit = 1'b0;
      end
      return d;
   endfunction

endpackage

/* File: design/pad_output_mux.sv */
// per-pin output ownership multiplexers between peripheral and port latch
`timescale 1ns/1ps

module pad_output_mux #(
   parameter int WIDTH = 48
) (
   input wire logic [WIDTH-1:0] port_dir,
   input wire logic [WIDTH-1:0] port_lat,
   input wire logic [WIDTH-1:0] periph_en,
   input wire logic [WIDTH-1:0] periph_drive,
   input wire logic [WIDTH-1:0] periph_out,
   input wire logic [WIDTH-1:0] dedicated,
   output logic [WIDTH-1:0] pad_out,
   output logic [WIDTH-1:0] pad_oe
);

   // =====================================================
   // one data mux and one enable mux per pin
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_pin
         logic periph_owns; // peripheral has taken the pad
         // input-only alternates never compete for the pad
         assign periph_owns = periph_en[i] & periph_drive[i] & ~dedicated[i];
         // peripheral wins data and enable; else latch drives when direction is clear
         assign pad_out[i] = periph_owns ? periph_out[i] : port_lat[i];
         assign pad_oe[i] = periph_owns ? 1'b1 : ~port_dir[i];
      end
   endgenerate

endmodule

/* File: verif/pad_partner.sv */
// pad-side model: resolves every pin from the block's driver and the board
`timescale 1ns/1ps

module pad_partner (
   input wire logic [47:0] pin_out,
   input wire logic [47:0] pin_oe,
   input wire logic [47:0] board_level,
   output logic [47:0] pin_in
);
   // =====================================
   // wire level: a driven pad shows the driver, a released one the board
   always_comb begin
      pin_in = (pin_oe & pin_out) | (~pin_oe & board_level);
   end
endmodule

/* File: verif/shared_parallel_io_port_tb.sv */
// self-checking bench for the shared parallel io port
`timescale 1ns/1ps

module shared_parallel_io_port_tb;
   // =====================================
   // bus, pad and bench state
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs;
   logic [47:0] pin_in, pin_out, pin_oe, periph_en, periph_drive, periph_out, board_level;
   logic [15:0] apc, analog_route;
   int n_fail = 0;
   int checks_done = 0;
   int cyc = 0;
   // one table row: optional write, then a read and its expected word
   typedef struct {
      logic wr;
      logic [9:0] widx;
      logic [15:0] wd;
      logic [9:0] ridx;
      logic [15:0] exp;
   } row_type;
   row_type rows [14];

   shared_parallel_io_port #(.DEDICATED_MASK(48'h0000_0000_0200)) u_shared_parallel_io_port (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_en(periph_en),
      .periph_drive(periph_drive), .periph_out(periph_out),
      .analog_pin_config(apc), .analog_route(analog_route)
   );
   pad_partner u_pad_partner (.pin_out(pin_out), .pin_oe(pin_oe), .board_level(board_level), .pin_in(pin_in));

   // =====================================
   // clock and hang guard
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         conclude();
      end
   end

   // =====================================
   // compare and bus tasks
   task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_pin(input string what, input logic [47:0] exp, input logic [47:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // handshakes are judged at the falling edge, where nothing changes before the next rise
   task automatic axi_wr(input logic [9:0] idx, input logic [15:0] d, input logic [3:0] st, output logic [1:0] r);
      logic ah, wh, bh;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {16'h0000, d};
      wstrb <= st;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      bh = 1'b0;
      while (!bh) begin
         @(negedge aclk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         bh = bvalid && bready;
         r = bresp;
         @(posedge aclk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
         if (bh) bready <= 1'b0;
      end
   endtask
   task automatic axi_rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
      logic ah, rh;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      rh = 1'b0;
      while (!rh) begin
         @(negedge aclk);
         ah = arvalid && arready;
         rh = rvalid && rready;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ah) arvalid <= 1'b0;
         if (rh) rready <= 1'b0;
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // =====================================
   // main sequence
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb, apc} = '0;
      {periph_en, periph_drive, periph_out, board_level} = '0;
      rows = '{
         '{0, 0, 0, gpio_pkg::PORT_A_DIR_IDX, 16'hC600}, '{0, 0, 0, gpio_pkg::PORT_A_LEVEL_IDX, 16'h0000},
         '{0, 0, 0, gpio_pkg::PORT_A_LAT_IDX, 16'h0000}, '{0, 0, 0, gpio_pkg::PORT_B_DIR_IDX, 16'hFFFF},
         '{0, 0, 0, gpio_pkg::PORT_B_LEVEL_IDX, 16'h0000}, '{0, 0, 0, gpio_pkg::PORT_B_LAT_IDX, 16'h0000},
         '{0, 0, 0, gpio_pkg::PORT_C_DIR_IDX, 16'hE00A}, '{0, 0, 0, gpio_pkg::PORT_C_LEVEL_IDX, 16'h0000},
         '{0, 0, 0, gpio_pkg::PORT_C_LAT_IDX, 16'h0000},
         '{1, gpio_pkg::PORT_A_LAT_IDX, 16'hFFFF, gpio_pkg::PORT_A_LAT_IDX, 16'hC600},
         '{1, gpio_pkg::PORT_B_LEVEL_IDX, 16'h1234, gpio_pkg::PORT_B_LAT_IDX, 16'h1234},
         '{1, gpio_pkg::PORT_C_LEVEL_IDX, 16'hFFFF, gpio_pkg::PORT_C_LAT_IDX, 16'hE00A},
         '{1, gpio_pkg::PORT_A_DIR_IDX, 16'h0000, gpio_pkg::PORT_A_DIR_IDX, 16'h0000},
         '{1, gpio_pkg::PORT_C_DIR_IDX, 16'h1FF5, gpio_pkg::PORT_C_DIR_IDX, 16'h0000}};
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            axi_wr(rows[i].widx, rows[i].wd, 4'hF, rs);
            chk_reg("write resp", {30'h0, gpio_pkg::RESP_OKAY}, {30'h0, rs});
         end
         axi_rd(rows[i].ridx, rd, rs);
         chk_reg("table read", {16'h0000, rows[i].exp}, rd);
         chk_reg("read resp", {30'h0, gpio_pkg::RESP_OKAY}, {30'h0, rs});
      end
      $display("test register table done");
      // ports a and c now drive their latches on implemented bits only
      @(negedge aclk);
      chk_pin("pad enable", 48'hE00A_0000_C600, pin_oe);
      chk_pin("pad data", 48'hE00A_0000_C600, pin_out & pin_oe);
      repeat (4) @(posedge aclk);
      axi_rd(gpio_pkg::PORT_A_LEVEL_IDX, rd, rs);
      chk_reg("driven level", 32'h0000_C600, rd);
      $display("test port drive done");
      // peripheral drives a15, a14 and b0; a10 stays with the latch, dedicated a9 ignores it
      periph_en <= '1;
      periph_drive <= 48'h0000_0001_C200;
      periph_out <= 48'h0000_0001_4000;
      @(negedge aclk);
      chk_pin("owned enable", 48'hE00A_0001_C600, pin_oe);
      chk_pin("owned data", 48'hE00A_0001_4600, pin_out & pin_oe);
      repeat (4) @(posedge aclk);
      axi_rd(gpio_pkg::PORT_A_LEVEL_IDX, rd, rs);
      chk_reg("owned level", 32'h0000_4600, rd);
      periph_en <= '0;
      periph_drive <= '0;
      $display("test peripheral priority done");
      // low half of port b as analog inputs, direction left as input
      board_level <= 48'h0000_FFFE_0000;
      apc <= 16'h00FF;
      repeat (4) @(posedge aclk);
      axi_rd(gpio_pkg::PORT_B_LEVEL_IDX, rd, rs);
      chk_reg("analog level", 32'h0000_FF00, rd);
      chk_reg("analog route", 32'h0000_00FF, {16'h0000, analog_route});
      $display("test analog pins done");
      // low byte strobe only, then an unmapped word
      axi_wr(gpio_pkg::PORT_B_LAT_IDX, 16'hABCD, 4'h1, rs);
      axi_rd(gpio_pkg::PORT_B_LAT_IDX, rd, rs);
      chk_reg("strobe latch", 32'h0000_12CD, rd);
      axi_wr(10'h2C1, 16'hFFFF, 4'hF, rs);
      chk_reg("unmapped wresp", {30'h0, gpio_pkg::RESP_SLVERR}, {30'h0, rs});
      axi_rd(10'h2C1, rd, rs);
      chk_reg("unmapped rresp", {30'h0, gpio_pkg::RESP_SLVERR}, {30'h0, rs});
      chk_reg("unmapped data", 32'h0, rd);
      $display("test strobe and unmapped done");
      // second reset in mid-run
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk_pin("reset enable", 48'h0, pin_oe);
      axi_rd(gpio_pkg::PORT_A_DIR_IDX, rd, rs);
      chk_reg("reset dir", 32'h0000_C600, rd);
      axi_rd(gpio_pkg::PORT_B_LAT_IDX, rd, rs);
      chk_reg("reset latch", 32'h0, rd);
      $display("test second reset done");
      conclude();
   end
endmodule
